// *** logic/dac_pkg.sv ***
// Shared constants for the converter digital front end
package dac_pkg;
  // ********************
  // Widths and sizes
  // ********************
  localparam int DATA_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
  localparam int PADDR_W = 8;
  localparam int PIN_W = DATA_W + 4;
  // Synchroniser reset image: {data, mode, clock type, sleep/select, format}
  localparam logic [PIN_W-1:0] PIN_SYNC_RST = 16'h0008;
  localparam int PIN_MODE = 3;
  localparam int PIN_CLKT = 2;
  localparam int PIN_SLEEP = 1;
  localparam int PIN_FMT = 0;
  // ********************
  // APB register map
  // ********************
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_CODE = 8'h08;
  localparam int CTRL_CAPEN = 0;
  localparam int CTRL_FLUSH = 1;
  localparam logic CTRL_CAPEN_RST = 1'b1;
  localparam int ST_SERIAL = 0;
  localparam int ST_TWOS = 1;
  localparam int ST_DIFF = 2;
  localparam int ST_PD = 3;
  localparam int ST_FULL = 4;
  localparam int ST_EMPTY = 5;
  localparam int ST_LVL = 8;
  localparam int ST_OVF = 16;
  // ********************
  // Serial port
  // ********************
  localparam int SPI_BYTE = 8;
  localparam int SPI_AW = 7;
  localparam logic [SPI_AW-1:0] SPI_CFG = 7'h00;
  localparam logic [SPI_AW-1:0] SPI_SCRATCH = 7'h01;
  localparam int SPI_PD = 0;
  localparam int SPI_TWOS = 1;
  localparam int SPI_DIFF = 2;
  localparam logic [SPI_BYTE-1:0] SPI_CFG_RST = 8'h00;
  localparam logic [SPI_BYTE-1:0] SPI_SCRATCH_RST = 8'h00;
  typedef enum logic [1:0] {SP_IDLE, SP_ADDR, SP_DATA} spi_state_e;
endpackage : dac_pkg

// *** logic/sync2.sv ***
// Two flip-flop synchroniser for slow levels
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync2

// *** logic/sample_fifo.sv ***
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  // Depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign inReady = count_r != (AW+1)'(DEPTH);
  assign outValid = count_r != '0;
  assign outData = mem[rdPtr_r];
  assign level = count_r;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule : sample_fifo

// *** logic/dac_config_pin_interface.sv ***
// Converter front end: data capture, strap/serial configuration, APB status
// How it works
// [RQ1] Mode pin high selects strap configuration, low selects the serial port.
// [RQ2] Mode pin high returns every serial-port register to its default.
// [RQ3] Strap mode: format strap low is straight binary, high twos complement.
// [RQ4] Strap mode: clock-type strap low single-ended clock, high differential.
// [RQ5] Serial mode: format pin is the two-way serial data line.
// [RQ6] Serial mode: clock-type pin is the serial clock from the host.
// [RQ7] Strap mode: sleep/select pin high powers the converter down.
// [RQ8] Serial mode: sleep/select pin is an active-low select for each transfer.
// [RQ9] Host presents twelve data bits, most significant on line eleven.
// [RQ10] All ones: full scale on primary output; all zeros: on complementary.
// [RQ11] Word captured every clock; twos complement inverts the top bit.
`timescale 1ns/1ps
module dac_config_pin_interface (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dac_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins
  input wire logic [dac_pkg::DATA_W-1:0] dataPin,
  input wire logic modePin,
  input wire logic clockTypeStrap,
  input wire logic sleepOrSelectPin,
  input wire logic formatIn,
  output logic formatOut,
  output logic formatOe,
  // Converter core
  output logic [dac_pkg::DATA_W-1:0] dacCode,
  output logic primaryFullScale,
  output logic complementaryFullScale,
  output logic clkDiffSel,
  output logic powerDown,
  output logic serialMode
);
  localparam int DW = dac_pkg::DATA_W;
  localparam int BW = dac_pkg::SPI_BYTE;

  // ********************
  // Reset and pin synchronisers
  // ********************
  logic rstSn;
  logic [dac_pkg::PIN_W-1:0] pinS;
  logic [DW-1:0] dataS;
  logic modeS;
  logic sclkS;
  logic csS;
  logic sdioS;

  sync2 #(.W(1), .INIT(1'b0)) uRstSync (
    .clk(mclk),
    .rstn(rstn),
    .d(1'b1),
    .q(rstSn)
  );

  sync2 #(.W(dac_pkg::PIN_W), .INIT(dac_pkg::PIN_SYNC_RST)) uPinSync (
    .clk(mclk),
    .rstn(rstSn),
    .d({dataPin, modePin, clockTypeStrap, sleepOrSelectPin, formatIn}),
    .q(pinS)
  );

  assign dataS = pinS[dac_pkg::PIN_W-1 -: DW];
  assign modeS = pinS[dac_pkg::PIN_MODE];
  assign sclkS = pinS[dac_pkg::PIN_CLKT];
  assign csS = pinS[dac_pkg::PIN_SLEEP];
  assign sdioS = pinS[dac_pkg::PIN_FMT];

  // ********************
  // Serial port
  // ********************
  dac_pkg::spi_state_e spState_r;
  logic sclkD_r;
  logic sclkRise;
  logic sclkFall;
  logic spiActive;
  logic endBit;
  logic [2:0] bitCnt_r;
  logic [BW-1:0] shiftIn_r;
  logic [BW-1:0] readShift_r;
  logic rw_r;
  logic [dac_pkg::SPI_AW-1:0] addr_r;
  logic [dac_pkg::SPI_AW-1:0] addrIn;
  logic [BW-1:0] byteIn;
  logic [BW-1:0] spiCfg_r;
  logic [BW-1:0] spiScratch_r;
  logic [BW-1:0] rdByte;

  function automatic logic [BW-1:0] spiRead(input logic [dac_pkg::SPI_AW-1:0] a,
                                            input logic [BW-1:0] cfg,
                                            input logic [BW-1:0] scr);
    logic [BW-1:0] v;
    v = '0;
    if (a == dac_pkg::SPI_CFG) begin
      v = cfg;
    end else if (a == dac_pkg::SPI_SCRATCH) begin
      v = scr;
    end
    return v;
  endfunction : spiRead

  // Serial clock is oversampled; host must keep it well below mclk/4
  assign sclkRise = sclkS && !sclkD_r;
  assign sclkFall = !sclkS && sclkD_r;
  assign spiActive = !modeS && !csS; // RQ8
  assign endBit = sclkRise && bitCnt_r == 3'h7;
  assign addrIn = {shiftIn_r[dac_pkg::SPI_AW-2:0], sdioS};
  assign byteIn = {shiftIn_r[BW-2:0], sdioS};
  assign rdByte = spiRead(addrIn, spiCfg_r, spiScratch_r);

  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      sclkD_r <= 1'b0;
    end else begin
      sclkD_r <= sclkS; // RQ6
    end
  end

  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      spState_r <= dac_pkg::SP_IDLE;
    end else if (!spiActive) begin
      spState_r <= dac_pkg::SP_IDLE; // RQ8
    end else begin
      unique case (spState_r)
        dac_pkg::SP_IDLE: begin
          spState_r <= dac_pkg::SP_ADDR;
        end
        dac_pkg::SP_ADDR: begin
          if (endBit) begin
            spState_r <= dac_pkg::SP_DATA;
          end
        end
        dac_pkg::SP_DATA: begin
          if (endBit) begin
            spState_r <= dac_pkg::SP_ADDR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      bitCnt_r <= '0;
      shiftIn_r <= '0;
    end else if (!spiActive || spState_r == dac_pkg::SP_IDLE) begin
      bitCnt_r <= '0;
    end else if (sclkRise) begin
      bitCnt_r <= bitCnt_r + 1'b1; // RQ6
      shiftIn_r <= byteIn;
    end
  end

  // First bit of each instruction is read/write, then seven address bits
  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      rw_r <= 1'b0;
      addr_r <= '0;
    end else if (spState_r == dac_pkg::SP_ADDR && endBit) begin
      rw_r <= shiftIn_r[dac_pkg::SPI_AW-1];
      addr_r <= addrIn;
    end
  end

  // Held at defaults for as long as the mode pin stays high
  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      spiCfg_r <= dac_pkg::SPI_CFG_RST;
      spiScratch_r <= dac_pkg::SPI_SCRATCH_RST;
    end else if (modeS) begin
      spiCfg_r <= dac_pkg::SPI_CFG_RST; // RQ2
      spiScratch_r <= dac_pkg::SPI_SCRATCH_RST; // RQ2
    end else if (spiActive && spState_r == dac_pkg::SP_DATA && endBit && !rw_r) begin
      if (addr_r == dac_pkg::SPI_CFG) begin
        spiCfg_r <= byteIn;
      end
      if (addr_r == dac_pkg::SPI_SCRATCH) begin
        spiScratch_r <= byteIn;
      end
    end
  end

  // Read data changes on the falling serial clock so the host samples on rising;
  // the first data fall presents the top bit again so it stands a full period
  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      readShift_r <= '0;
      formatOut <= 1'b0;
    end else if (spState_r == dac_pkg::SP_ADDR && endBit) begin
      readShift_r <= rdByte;
      formatOut <= rdByte[BW-1]; // RQ5
    end else if (spState_r == dac_pkg::SP_DATA && sclkFall) begin
      readShift_r <= {readShift_r[BW-2:0], 1'b0};
      formatOut <= readShift_r[BW-1]; // RQ5
    end
  end

  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      formatOe <= 1'b0;
    end else begin
      formatOe <= spiActive && // RQ5
                  ((spState_r == dac_pkg::SP_ADDR && endBit && shiftIn_r[dac_pkg::SPI_AW-1]) ||
                   (spState_r == dac_pkg::SP_DATA && rw_r && !endBit));
    end
  end

  // ********************
  // Configuration select
  // ********************
  logic twos_r;

  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      serialMode <= 1'b0;
      twos_r <= 1'b0;
      clkDiffSel <= 1'b0;
      powerDown <= 1'b0;
    end else begin
      serialMode <= !modeS; // RQ1
      twos_r <= modeS ? sdioS : spiCfg_r[dac_pkg::SPI_TWOS]; // RQ3
      clkDiffSel <= modeS ? sclkS : spiCfg_r[dac_pkg::SPI_DIFF]; // RQ4
      powerDown <= modeS ? csS : spiCfg_r[dac_pkg::SPI_PD]; // RQ7
    end
  end

  // ********************
  // Data path
  // ********************
  logic capEn_r;
  logic flush_r;
  logic ovf_r;
  logic capValid;
  logic capReady;
  logic [DW-1:0] capWord;
  logic fifoValid;
  logic fifoReady;
  logic [DW-1:0] fifoData;
  logic [dac_pkg::LVL_W-1:0] fifoLevel;

  assign capValid = capEn_r && !flush_r;
  assign capWord = dataS ^ {twos_r, {(DW-1){1'b0}}}; // RQ11
  // A sleeping converter consumes nothing, so the FIFO fills behind it
  assign fifoReady = !powerDown;

  sample_fifo #(.W(DW), .DEPTH(dac_pkg::FIFO_DEPTH)) uFifo (
    .clk(mclk),
    .rstn(rstSn),
    .flush(flush_r),
    .inValid(capValid),
    .inData(capWord),
    .inReady(capReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoReady),
    .level(fifoLevel)
  );

  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      dacCode <= '0;
      primaryFullScale <= 1'b0;
      complementaryFullScale <= 1'b1;
    end else if (fifoValid && fifoReady) begin
      dacCode <= fifoData;
      primaryFullScale <= &fifoData; // RQ10
      complementaryFullScale <= ~|fifoData; // RQ10
    end
  end

  // ********************
  // APB slave
  // ********************
  logic setup;
  logic wrAcc;
  logic [31:0] status;

  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign status = {15'h0000, ovf_r, 3'h0, fifoLevel, 2'h0, !fifoValid, !capReady,
                   powerDown, clkDiffSel, twos_r, serialMode};

  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      capEn_r <= dac_pkg::CTRL_CAPEN_RST;
      flush_r <= 1'b0;
    end else begin
      flush_r <= wrAcc && paddr == dac_pkg::OFF_CTRL && pwdata[dac_pkg::CTRL_FLUSH];
      if (wrAcc && paddr == dac_pkg::OFF_CTRL) begin
        capEn_r <= pwdata[dac_pkg::CTRL_CAPEN];
      end
    end
  end

  // Dropped word sets the flag even in the cycle software clears it
  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      ovf_r <= 1'b0;
    end else if (capValid && !capReady) begin
      ovf_r <= 1'b1;
    end else if (wrAcc && paddr == dac_pkg::OFF_STATUS && pwdata[dac_pkg::ST_OVF]) begin
      ovf_r <= 1'b0;
    end
  end

  // Decoded in setup, so the answer stands in the first access cycle
  always_ff @(posedge mclk or negedge rstSn) begin
    if (!rstSn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= '0;
      if (setup) begin
        unique case (paddr)
          dac_pkg::OFF_CTRL: prdata <= {30'h0, 1'b0, capEn_r};
          dac_pkg::OFF_STATUS: prdata <= status;
          dac_pkg::OFF_CODE: prdata <= {20'h0, dacCode};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSn);

  sequence s_lastWrBit;
    spiActive && spState_r == dac_pkg::SP_DATA && endBit && !rw_r &&
      addr_r == dac_pkg::SPI_CFG;
  endsequence
  sequence s_cfgUpdated;
    ##1 spiCfg_r == $past(byteIn);
  endsequence

  property p_mode;
    ##1 serialMode == !$past(modeS);
  endproperty
  a_mode: assert property (p_mode) else $error("mode select wrong"); // RQ1
  property p_regReset;
    modeS |=> spiCfg_r == dac_pkg::SPI_CFG_RST && spiScratch_r == dac_pkg::SPI_SCRATCH_RST;
  endproperty
  a_regReset: assert property (p_regReset) else $error("serial regs not reset"); // RQ2
  property p_format;
    modeS |=> twos_r == $past(sdioS);
  endproperty
  a_format: assert property (p_format) else $error("format strap ignored"); // RQ3
  property p_clkType;
    modeS |=> clkDiffSel == $past(sclkS);
  endproperty
  a_clkType: assert property (p_clkType) else $error("clock type wrong"); // RQ4
  property p_sdioOe;
    modeS || csS |=> !formatOe;
  endproperty
  a_sdioOe: assert property (p_sdioOe) else $error("data line driven"); // RQ5
  property p_sclkCount;
    spiActive && spState_r != dac_pkg::SP_IDLE && sclkRise |=>
      bitCnt_r == $past(bitCnt_r) + 3'h1 || !spiActive;
  endproperty
  a_sclkCount: assert property (p_sclkCount) else $error("clock edge lost"); // RQ6
  property p_sleep;
    modeS |=> powerDown == $past(csS);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep pin ignored"); // RQ7
  property p_select;
    csS |=> spState_r == dac_pkg::SP_IDLE;
  endproperty
  a_select: assert property (p_select) else $error("deselect ignored"); // RQ8
  property p_cfgWrite;
    s_lastWrBit |-> s_cfgUpdated;
  endproperty
  a_cfgWrite: assert property (p_cfgWrite) else $error("config write lost"); // RQ5
  property p_fullScale;
    fifoValid && fifoReady |=> primaryFullScale == (&dacCode) &&
      complementaryFullScale == (~|dacCode);
  endproperty
  a_fullScale: assert property (p_fullScale) else $error("full scale flag wrong"); // RQ10
  property p_msb;
    ##1 capWord[DW-1] == (dataS[DW-1] ^ $past(modeS ? sdioS : spiCfg_r[dac_pkg::SPI_TWOS]));
  endproperty
  a_msb: assert property (p_msb) else $error("top bit coding wrong"); // RQ11
endmodule : dac_config_pin_interface

// *** sim/host_serial.sv ***
// Host model: serial-port master for the converter configuration port
`timescale 1ns/1ps
module host_serial (
  // Clock
  input wire logic mclk,
  // Serial wire
  input wire logic sdioIn,
  output logic sclk,
  output logic selectN,
  output logic sdioDrv,
  output logic sdioOe
);
  initial begin
    sclk = 1'b0;
    selectN = 1'b1;
    sdioDrv = 1'b0;
    sdioOe = 1'b0;
  end

  // Phase is in mclk cycles; four is the shortest the port accepts
  task automatic xfer(input logic rdOp, input logic [6:0] addr, input logic [7:0] wrData,
                      input int phase, output logic [7:0] rdData);
    logic [15:0] bits;
    bits = {rdOp, addr, wrData};
    rdData = 8'h00;
    @(posedge mclk);
    selectN <= 1'b0;
    repeat (phase) @(posedge mclk);
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b0;
      sdioOe <= (i > 7) || !rdOp;
      sdioDrv <= bits[i];
      repeat (phase) @(posedge mclk);
      // Read bits are taken at the rising serial edge; the device changed them after the fall
      if (i < 8) begin
        rdData[i] = sdioIn;
      end
      sclk <= 1'b1;
      repeat (phase) @(posedge mclk);
    end
    sclk <= 1'b0;
    sdioOe <= 1'b0;
    repeat (phase) @(posedge mclk);
    selectN <= 1'b1;
    repeat (phase) @(posedge mclk);
  endtask : xfer
endmodule : host_serial

// *** sim/tb_top.sv ***
// Self-checking testbench for the converter front end
`timescale 1ns/1ps
module tb_top;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [dac_pkg::PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [dac_pkg::DATA_W-1:0] dataPin, dacCode;
  logic modePin, fmtStrap, clkTypeStrap, sleepStrap, formatOut, formatOe;
  logic primaryFullScale, complementaryFullScale, clkDiffSel, powerDown, serialMode;
  logic sclk, selectN, hostDrv, hostOe, sdioWire;
  logic [7:0] sd;
  int error_cnt, checked;
  typedef struct {logic fmt; logic ctype; logic [11:0] data; logic [11:0] code;} row_s;
  row_s rows[6] = '{'{0, 0, 12'hfff, 12'hfff}, '{0, 1, 12'h000, 12'h000},
                    '{1, 0, 12'h7ff, 12'hfff}, '{1, 1, 12'h800, 12'h000},
                    '{0, 1, 12'h5a3, 12'h5a3}, '{1, 0, 12'h5a3, 12'hda3}};
  localparam logic [31:0] FULL_ST = (32'd16 << dac_pkg::ST_LVL) | (32'd1 << dac_pkg::ST_FULL)
                                    | (32'd1 << dac_pkg::ST_PD);
  localparam logic [31:0] OVF = 32'd1 << dac_pkg::ST_OVF;

  // Nobody driving: show the inverse of the last host bit, never a held value
  assign sdioWire = hostOe ? hostDrv : (formatOe ? formatOut : ~hostDrv);

  dac_config_pin_interface u_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dataPin(dataPin), .modePin(modePin),
    .clockTypeStrap(modePin ? clkTypeStrap : sclk),
    .sleepOrSelectPin(modePin ? sleepStrap : selectN),
    .formatIn(modePin ? fmtStrap : sdioWire), .formatOut(formatOut), .formatOe(formatOe),
    .dacCode(dacCode), .primaryFullScale(primaryFullScale),
    .complementaryFullScale(complementaryFullScale), .clkDiffSel(clkDiffSel),
    .powerDown(powerDown), .serialMode(serialMode));

  host_serial u_host (.mclk(mclk), .sdioIn(sdioWire), .sclk(sclk), .selectN(selectN),
    .sdioDrv(hostDrv), .sdioOe(hostOe));

  // ********************
  // Checking and bus tasks
  // ********************
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : apb

  task automatic waitCode(input logic [11:0] exp);
    int n;
    n = 0;
    while (dacCode !== exp && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk(dacCode, exp);
    if (n >= 40) begin
      tally_and_finish();
    end
  endtask : waitCode

  // ********************
  // Main sequence
  // ********************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    dataPin = 12'h000;
    {modePin, fmtStrap, clkTypeStrap, sleepStrap} = 4'h8;
    error_cnt = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    apb(1'b0, dac_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    foreach (rows[i]) begin
      @(posedge mclk);
      fmtStrap <= rows[i].fmt;
      clkTypeStrap <= rows[i].ctype;
      dataPin <= rows[i].data;
      waitCode(rows[i].code);
      chk(primaryFullScale, &rows[i].code);
      chk(complementaryFullScale, ~|rows[i].code);
      chk(clkDiffSel, rows[i].ctype);
      chk({serialMode, powerDown}, 32'h0);
    end
    apb(1'b0, dac_pkg::OFF_CODE, 32'h0);
    chk(rd, 32'hda3);
    // Power-down stalls the drain, so the FIFO fills and then drops words
    fmtStrap <= 1'b0;
    sleepStrap <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(powerDown, 1);
    apb(1'b0, dac_pkg::OFF_STATUS, 32'h0);
    chk(rd, FULL_ST | OVF);
    // Stop capture and flush the full FIFO in one write
    apb(1'b1, dac_pkg::OFF_CTRL, 32'h2);
    apb(1'b1, dac_pkg::OFF_STATUS, OVF);
    apb(1'b0, dac_pkg::OFF_STATUS, 32'h0);
    chk(rd, (32'd1 << dac_pkg::ST_PD) | (32'd1 << dac_pkg::ST_EMPTY));
    sleepStrap <= 1'b0;
    repeat (40) @(posedge mclk);
    apb(1'b0, dac_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'd1 << dac_pkg::ST_EMPTY);
    apb(1'b1, dac_pkg::OFF_CTRL, 32'h1);
    modePin <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({serialMode, formatOe}, 32'h2);
    u_host.xfer(1'b0, dac_pkg::SPI_CFG, 8'h06, 4, sd);
    repeat (8) @(posedge mclk);
    chk({clkDiffSel, powerDown}, 32'h2);
    u_host.xfer(1'b1, dac_pkg::SPI_CFG, 8'h00, 4, sd);
    chk(sd, 8'h06);
    u_host.xfer(1'b0, dac_pkg::SPI_SCRATCH, 8'ha5, 7, sd);
    u_host.xfer(1'b1, dac_pkg::SPI_SCRATCH, 8'h00, 5, sd);
    chk(sd, 8'ha5);
    u_host.xfer(1'b1, 7'h05, 8'h00, 4, sd);
    chk(sd, 8'h00);
    apb(1'b0, dac_pkg::OFF_STATUS, 32'h0);
    chk(rd[0], 1);
    @(posedge mclk);
    modePin <= 1'b1;
    repeat (6) @(posedge mclk);
    modePin <= 1'b0;
    repeat (8) @(posedge mclk);
    u_host.xfer(1'b1, dac_pkg::SPI_CFG, 8'h00, 4, sd);
    chk(sd, 8'h00);
    chk(clkDiffSel, 0);
    tally_and_finish();
  end
endmodule : tb_top
